// >>> rbcs_top.v
// Reset sequencing, strap capture and segment port logic of the microcontroller.
`timescale 1ns/1ps
`include "rbcs_consts.vh"

// Notes on behaviour
// - Straps are sampled during hardware reset to choose single-chip or external bus.
// - Codes 000/001/010/011 pick bus width and muxing, 100 single-chip, rest reserved.
// - Segment port has two pins, each with its own direction bit.
// - A pin set as input has its driver turned off.
// - With an external bus, the pins can carry address bits 16 and 17.
// - Reset pin held low for the minimum time causes a hardware reset.
// - Reset indication goes low on hardware, software and watchdog resets.
// - Reset indication stays low until end of initialisation, then goes high.
// - The core clock is the oscillator clock with no divider.
module rbcs_top (
  // Clock and reset.
  input wire clk_sys,
  input wire rst,
  // Board reset pin and straps.
  input wire resetRequestInN,
  input wire busActiveStrap,
  input wire busCfgStrapHi,
  input wire busCfgStrapLo,
  // Core events.
  input wire endOfInitInstruction,
  input wire watchdogResetReq,
  input wire [1:0] segAddr,
  // Register port.
  input wire [7:0] regAddr,
  input wire [15:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [15:0] regRdData_q,
  // Reset outputs.
  output wire resetIndicationOutN,
  output wire coreReset,
  output wire coreClk,
  // Latched bus configuration.
  output wire extBusActive,
  output wire busWide16,
  output wire busMultiplexed,
  output wire cfgReserved,
  // Segment port pins.
  input wire segmentPortPinLoIn,
  output wire segmentPortPinLoOut,
  output wire segmentPortPinLoOe,
  input wire segmentPortPinHiIn,
  output wire segmentPortPinHiOut,
  output wire segmentPortPinHiOe
);

  // Minimum reset pulse in cycles, rounded up.
  localparam integer RST_MIN_CYC_I =
    (`RBCS_RST_MIN_NS + `RBCS_CLK_PERIOD_NS - 1) / `RBCS_CLK_PERIOD_NS;
  localparam [`RBCS_CNT_W-1:0] RST_MIN_CYC = RST_MIN_CYC_I[`RBCS_CNT_W-1:0];
  localparam [`RBCS_CNT_W-1:0] CNT_ONE = 8'h01;

  wire resetPinN;
  wire [2:0] strapSync;
  wire [1:0] pinSync;
  wire [1:0] pinOutW;
  wire [1:0] pinOeW;
  wire hwTrigger;
  wire swTrigger;
  wire ctrlSel;
  wire statSel;
  wire cmdSel;
  // Decode of the strap sample that the next release latches.
  wire sampleExt;
  wire sampleWide;
  wire sampleMux;
  wire sampleRsvd;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`RBCS_CNT_W-1:0] lowCnt_q;
  reg [`RBCS_CNT_W-1:0] lowCnt_d;
  reg [2:0] strapSample_q;
  reg [2:0] cfgCode_q;
  reg cfgValid_q;
  reg [1:0] cause_q;
  reg [1:0] cause_d;
  reg [`RBCS_CTRL_W-1:0] ctrl_q;
  reg swReq_q;
  reg indication_q;
  reg [15:0] statWord;
  // Latched decode of the strap code.
  reg extBus_q;
  reg wide16_q;
  reg muxed_q;
  reg reserved_q;

  // Reset pin goes through the three-stage filter; idle level is high.
  rbcs_sync3 #(
    .W(1),
    .INIT(1'b1)
  ) u_rst_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .asyncIn(resetRequestInN),
    .syncOut_q(resetPinN)
  );

  // Strap pins are filtered the same way before sampling.
  rbcs_sync3 #(
    .W(3),
    .INIT(`RBCS_CODE_SINGLE)
  ) u_strap_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .asyncIn({busActiveStrap, busCfgStrapHi, busCfgStrapLo}),
    .syncOut_q(strapSync)
  );

  // Pin read-back levels for the status register.
  rbcs_sync3 #(
    .W(2),
    .INIT(2'h0)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .asyncIn({segmentPortPinHiIn, segmentPortPinLoIn}),
    .syncOut_q(pinSync)
  );

  // Address decode of the register port.
  assign ctrlSel = (regAddr == `RBCS_OFS_CTRL);
  assign statSel = (regAddr == `RBCS_OFS_STAT);
  assign cmdSel = (regAddr == `RBCS_OFS_CMD);

  // A hardware reset needs the pin low for the full minimum time.
  assign hwTrigger = (lowCnt_q == RST_MIN_CYC);
  assign swTrigger = swReq_q || watchdogResetReq;

  // Low-time counter saturates at the minimum and clears when the pin rises.
  always @* begin
    lowCnt_d = lowCnt_q;
    if (resetPinN) begin
      lowCnt_d = {`RBCS_CNT_W{1'b0}};
    end else if (lowCnt_q != RST_MIN_CYC) begin
      lowCnt_d = lowCnt_q + CNT_ONE;
    end
  end

  // Sequencer: hardware reset wins over watchdog, which wins over software.
  always @* begin
    state_d = state_q;
    cause_d = cause_q;
    case (state_q)
      `RBCS_ST_RUN, `RBCS_ST_INIT: begin
        if (hwTrigger) begin
          state_d = `RBCS_ST_HW;
          cause_d = `RBCS_CAUSE_HW;
        end else if (swTrigger) begin
          // The watchdog names the cause when both requests meet.
          state_d = `RBCS_ST_SOFT;
          if (watchdogResetReq) begin
            cause_d = `RBCS_CAUSE_WDT;
          end else begin
            cause_d = `RBCS_CAUSE_SW;
          end
        end else if (state_q == `RBCS_ST_INIT && endOfInitInstruction) begin
          state_d = `RBCS_ST_RUN;
        end
      end
      `RBCS_ST_HW: begin
        if (resetPinN) begin
          state_d = `RBCS_ST_INIT;
        end
      end
      `RBCS_ST_SOFT: begin
        state_d = `RBCS_ST_INIT;
      end
      default: begin
        state_d = `RBCS_ST_INIT;
      end
    endcase
  end

  // State, counter and cause registers.
  always @(posedge clk_sys) begin
    if (rst) begin
      state_q <= `RBCS_ST_INIT;
      lowCnt_q <= {`RBCS_CNT_W{1'b0}};
      cause_q <= `RBCS_CAUSE_NONE;
    end else begin
      state_q <= state_d;
      lowCnt_q <= lowCnt_d;
      cause_q <= cause_d;
    end
  end

  // Indication is low in every state except normal running.
  always @(posedge clk_sys) begin
    if (rst) begin
      indication_q <= 1'b0;
    end else begin
      indication_q <= (state_d == `RBCS_ST_RUN);
    end
  end

  assign resetIndicationOutN = indication_q;
  assign coreReset = (state_q == `RBCS_ST_HW) || (state_q == `RBCS_ST_SOFT);

  // The core runs straight from the oscillator clock.
  assign coreClk = clk_sys;

  // Straps are sampled every cycle of a hardware reset and latched at release.
  always @(posedge clk_sys) begin
    if (rst) begin
      strapSample_q <= `RBCS_CODE_SINGLE;
      cfgCode_q <= `RBCS_CODE_SINGLE;
      cfgValid_q <= 1'b0;
      extBus_q <= 1'b0;
      wide16_q <= 1'b0;
      muxed_q <= 1'b0;
      reserved_q <= 1'b0;
    end else begin
      if (state_q == `RBCS_ST_HW) begin
        strapSample_q <= strapSync;
        if (resetPinN) begin
          // The decode travels with the code so both change on one edge.
          cfgCode_q <= strapSample_q;
          cfgValid_q <= 1'b1;
          extBus_q <= sampleExt;
          wide16_q <= sampleWide;
          muxed_q <= sampleMux;
          reserved_q <= sampleRsvd;
        end
      end
    end
  end

  // Decode of the strap sample, registered with the code so the outputs come from flops.
  assign sampleExt = ~strapSample_q[`RBCS_CODE_ACTIVE_BIT];
  assign sampleWide = (strapSample_q == `RBCS_CODE_16MUX) ||
                      (strapSample_q == `RBCS_CODE_16DEMUX);
  assign sampleMux = (strapSample_q == `RBCS_CODE_8MUX) ||
                     (strapSample_q == `RBCS_CODE_16MUX);
  assign sampleRsvd = strapSample_q[`RBCS_CODE_ACTIVE_BIT] &&
                      (strapSample_q != `RBCS_CODE_SINGLE);

  // Latched configuration outputs.
  assign extBusActive = extBus_q;
  assign busWide16 = wide16_q;
  assign busMultiplexed = muxed_q;
  assign cfgReserved = reserved_q;

  // Control register; any core reset returns the pins to input.
  always @(posedge clk_sys) begin
    if (rst || coreReset) begin
      ctrl_q <= `RBCS_CTRL_RST;
    end else if (regWr && ctrlSel) begin
      ctrl_q <= regWrData[`RBCS_CTRL_W-1:0];
    end
  end

  // Software reset command is a one-cycle request into the sequencer.
  always @(posedge clk_sys) begin
    if (rst) begin
      swReq_q <= 1'b0;
    end else begin
      swReq_q <= regWr && cmdSel && regWrData[`RBCS_CMD_SWRST];
    end
  end

  // Segment pins; the address alternate output needs an external bus.
  rbcs_seg_port u_seg_port (
    .clk_sys(clk_sys),
    .rst(rst),
    .pinDir(ctrl_q[`RBCS_CTRL_DIR_LSB+1:`RBCS_CTRL_DIR_LSB]),
    .pinData(ctrl_q[`RBCS_CTRL_OUT_LSB+1:`RBCS_CTRL_OUT_LSB]),
    .segSelect(ctrl_q[`RBCS_CTRL_SEGEN] && extBusActive),
    .segAddr(segAddr),
    .pinOut_q(pinOutW),
    .pinOe_q(pinOeW)
  );

  assign segmentPortPinLoOut = pinOutW[0];
  assign segmentPortPinLoOe = pinOeW[0];
  assign segmentPortPinHiOut = pinOutW[1];
  assign segmentPortPinHiOe = pinOeW[1];

  // Status word assembly.
  always @* begin
    statWord = 16'h0000;
    statWord[`RBCS_STAT_CODE_LSB+2:`RBCS_STAT_CODE_LSB] = cfgCode_q;
    statWord[`RBCS_STAT_EXT] = extBusActive;
    statWord[`RBCS_STAT_RSVD] = cfgReserved;
    statWord[`RBCS_STAT_PIN_LSB+1:`RBCS_STAT_PIN_LSB] = pinSync;
    statWord[`RBCS_STAT_IND] = indication_q;
    statWord[`RBCS_STAT_CAUSE_LSB+1:`RBCS_STAT_CAUSE_LSB] = cause_q;
    statWord[`RBCS_STAT_VALID] = cfgValid_q;
  end

  // Read data stands one cycle after the strobe and is zero otherwise.
  always @(posedge clk_sys) begin
    if (rst) begin
      regRdData_q <= 16'h0000;
    end else if (regRd && ctrlSel) begin
      regRdData_q <= {{(`RBCS_DATA_W-`RBCS_CTRL_W){1'b0}}, ctrl_q};
    end else if (regRd && statSel) begin
      regRdData_q <= statWord;
    end else begin
      regRdData_q <= 16'h0000;
    end
  end

endmodule // rbcs_top

// >>> rbcs_consts.vh
// Constants for the reset and bus configuration select block.
`ifndef RBCS_CONSTS_VH
`define RBCS_CONSTS_VH

// Clock and minimum reset pulse timing.
`define RBCS_CLK_PERIOD_NS 25
`define RBCS_RST_MIN_NS 1000
`define RBCS_CNT_W 8

// Register bus layout.
`define RBCS_ADDR_W 8
`define RBCS_DATA_W 16
`define RBCS_OFS_CTRL 8'h00
`define RBCS_OFS_STAT 8'h04
`define RBCS_OFS_CMD 8'h08

// Control register fields.
`define RBCS_CTRL_DIR_LSB 0
`define RBCS_CTRL_OUT_LSB 2
`define RBCS_CTRL_SEGEN 4
`define RBCS_CTRL_RST 5'h00
`define RBCS_CTRL_W 5

// Status register fields.
`define RBCS_STAT_CODE_LSB 0
`define RBCS_STAT_EXT 3
`define RBCS_STAT_RSVD 4
`define RBCS_STAT_PIN_LSB 5
`define RBCS_STAT_IND 7
`define RBCS_STAT_CAUSE_LSB 8
`define RBCS_STAT_VALID 10

// Command register fields.
`define RBCS_CMD_SWRST 0

// Strap codes: bus-active, cfg1, cfg0.
`define RBCS_CODE_8DEMUX 3'h0
`define RBCS_CODE_8MUX 3'h1
`define RBCS_CODE_16MUX 3'h2
`define RBCS_CODE_16DEMUX 3'h3
`define RBCS_CODE_SINGLE 3'h4
`define RBCS_CODE_ACTIVE_BIT 2

// Reset causes.
`define RBCS_CAUSE_NONE 2'h0
`define RBCS_CAUSE_HW 2'h1
`define RBCS_CAUSE_SW 2'h2
`define RBCS_CAUSE_WDT 2'h3

// Sequencer states.
`define RBCS_ST_RUN 2'h0
`define RBCS_ST_HW 2'h1
`define RBCS_ST_SOFT 2'h2
`define RBCS_ST_INIT 2'h3

`endif

// >>> rbcs_sync3.v
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module rbcs_sync3 #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // Clock and reset.
  input wire clk_sys,
  input wire rst,
  // Asynchronous input and filtered result.
  input wire [W-1:0] asyncIn,
  output reg [W-1:0] syncOut_q
);

  reg [W-1:0] stage1_q;
  reg [W-1:0] stage2_q;
  reg [W-1:0] stage3_q;

  // Stage one feeds only stage two, so no logic sees a metastable value.
  always @(posedge clk_sys) begin
    if (rst) begin
      stage1_q <= INIT;
      stage2_q <= INIT;
      stage3_q <= INIT;
      syncOut_q <= INIT;
    end else begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      if (stage2_q == stage3_q) begin
        syncOut_q <= stage3_q;
      end
    end
  end

endmodule // rbcs_sync3

// >>> rbcs_seg_port.v
// Two-pin segment address port with per-pin direction and address alternate output.
`timescale 1ns/1ps
module rbcs_seg_port (
  // Clock and reset.
  input wire clk_sys,
  input wire rst,
  // Control from the register file.
  input wire [1:0] pinDir,
  input wire [1:0] pinData,
  input wire segSelect,
  // Upper address bits, bit 0 is A16 and bit 1 is A17.
  input wire [1:0] segAddr,
  // Pin drivers.
  output reg [1:0] pinOut_q,
  output reg [1:0] pinOe_q
);

  genvar i;

  // Each pin picks its level and enable on its own.
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_pin
      always @(posedge clk_sys) begin
        if (rst) begin
          pinOut_q[i] <= 1'b0;
          pinOe_q[i] <= 1'b0;
        end else begin
          pinOe_q[i] <= pinDir[i];
          pinOut_q[i] <= segSelect ? segAddr[i] : pinData[i];
        end
      end
    end
  endgenerate

endmodule // rbcs_seg_port

// >>> rbcs_board.sv
// Board model: reset pin with pull-up and the three configuration straps.
`timescale 1ns/1ps
module rbcs_board #(
  parameter ROMLESS = 0
) (
  // Clock.
  input wire clk_sys,
  // Pins toward the block.
  output reg resetRequestInN,
  output reg busActiveStrap,
  output reg busCfgStrapHi,
  output reg busCfgStrapLo
);
  // The pull-up keeps the pin high when nothing pulls it down.
  initial begin
    resetRequestInN = 1'b1;
    {busActiveStrap, busCfgStrapHi, busCfgStrapLo} = 3'h4;
  end
  // Pulls reset low long enough, then lets the straps wander after release.
  task pulse(input [2:0] c);
    {busActiveStrap, busCfgStrapHi, busCfgStrapLo} <= ROMLESS ? {1'b0, c[1:0]} : c;
    resetRequestInN <= 1'b0;
    repeat (50) @(posedge clk_sys);
    resetRequestInN <= 1'b1;
    repeat (8) @(posedge clk_sys);
    {busActiveStrap, busCfgStrapHi, busCfgStrapLo} <= ~c;
  endtask
  // Pulls reset low for too short a time to count as a hardware reset.
  task blip;
    resetRequestInN <= 1'b0;
    repeat (20) @(posedge clk_sys);
    resetRequestInN <= 1'b1;
  endtask
endmodule // rbcs_board

// >>> rbcs_top_chk.sv
// Checker for the reset and bus configuration select block.
`timescale 1ns/1ps
module rbcs_top_chk (
  // Clock and reset.
  input wire clk_sys,
  input wire rst,
  // Watched ports.
  input wire resetRequestInN,
  input wire endOfInitInstruction,
  input wire watchdogResetReq,
  input wire [7:0] regAddr,
  input wire [15:0] regWrData,
  input wire regWr,
  input wire regRd,
  input wire [15:0] regRdData_q,
  input wire resetIndicationOutN,
  input wire coreReset,
  input wire coreClk,
  input wire extBusActive,
  input wire cfgReserved,
  input wire segmentPortPinLoOe,
  input wire segmentPortPinHiOe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  reg [6:0] lowCnt_q;
  // Counts cycles of a low reset pin.
  always @(posedge clk_sys) begin
    if (rst || resetRequestInN) lowCnt_q <= 7'h00;
    else if (lowCnt_q != 7'h7f) lowCnt_q <= lowCnt_q + 7'h01;
  end
  chk_pin_reset: assert property (lowCnt_q == 7'h30 |-> coreReset)
    else $error("long low pin gave no reset");
  chk_clk_direct: assert property (@(negedge clk_sys) coreClk)
    else $error("core clock differs");
  chk_ind_in_reset: assert property (coreReset |-> !resetIndicationOutN)
    else $error("indication high in reset");
  chk_wdt_starts: assert property (watchdogResetReq |-> ##[1:3] coreReset)
    else $error("watchdog gave no reset");
  chk_ind_release: assert property ($rose(resetIndicationOutN) |-> $past(endOfInitInstruction))
    else $error("indication rose without end of init");
  chk_oe_follows: assert property (regWr && regAddr == 8'h00 && !coreReset
    ##1 !coreReset |=> {14'h0000, segmentPortPinHiOe, segmentPortPinLoOe} ==
    ($past(regWrData, 2) & 16'h0003)) else $error("enable not per direction");
  chk_cfg_stable: assert property (!coreReset && !$past(coreReset) && !$past(rst)
    |-> $stable({extBusActive, cfgReserved})) else $error("config moved");
  chk_rsvd_not_ext: assert property (cfgReserved |-> !extBusActive)
    else $error("reserved code gave bus");
  chk_rd_idle: assert property (!$past(regRd) |-> regRdData_q == 16'h0000)
    else $error("read data outside slot");
  // Main scenarios.
  cov_hw: cover property ($rose(coreReset) && !resetRequestInN);
  cov_wdt: cover property (watchdogResetReq ##1 coreReset);
  cov_init: cover property ($rose(resetIndicationOutN));
endmodule // rbcs_top_chk

// >>> tb.sv
// Self-checking testbench for the reset and bus configuration select block.
`timescale 1ns/1ps
`include "rbcs_consts.vh"
`define CHK(nm, e, s) begin total_checks = total_checks + 1; if ((s) !== (e)) begin \
  n_errors = n_errors + 1; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module tb;
  reg clk_sys = 1'b0;
  reg rst = 1'b1;
  reg endOfInitInstruction = 1'b0;
  reg watchdogResetReq = 1'b0;
  reg [1:0] segAddr = 2'h0;
  reg [7:0] regAddr = 8'h00;
  reg [15:0] regWrData = 16'h0000;
  reg regWr = 1'b0;
  reg regRd = 1'b0;
  reg extHi = 1'b1;
  wire resetRequestInN, busActiveStrap, busCfgStrapHi, busCfgStrapLo;
  wire [15:0] regRdData_q;
  wire resetIndicationOutN, coreReset, coreClk, extBusActive, busWide16, busMultiplexed;
  wire cfgReserved, segmentPortPinLoOut, segmentPortPinLoOe, segmentPortPinHiOut;
  wire segmentPortPinHiOe;
  integer n_errors = 0;
  integer total_checks = 0;
  integer i;
  reg [15:0] v;
  // Pin level: the block's driver when enabled, else the board's level.
  wire segmentPortPinLoIn = segmentPortPinLoOe ? segmentPortPinLoOut : 1'b0;
  wire segmentPortPinHiIn = segmentPortPinHiOe ? segmentPortPinHiOut : extHi;
  wire [3:0] pinView = {segmentPortPinHiOe, segmentPortPinHiOut,
    segmentPortPinLoOe, segmentPortPinLoOut};
  rbcs_board brd (.clk_sys, .resetRequestInN, .busActiveStrap, .busCfgStrapHi, .busCfgStrapLo);
  rbcs_top dut (.clk_sys, .rst, .resetRequestInN, .busActiveStrap, .busCfgStrapHi, .busCfgStrapLo,
    .endOfInitInstruction, .watchdogResetReq, .segAddr, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData_q, .resetIndicationOutN, .coreReset, .coreClk, .extBusActive, .busWide16,
    .busMultiplexed, .cfgReserved, .segmentPortPinLoIn, .segmentPortPinLoOut,
    .segmentPortPinLoOe, .segmentPortPinHiIn, .segmentPortPinHiOut, .segmentPortPinHiOe);
  // Clock source.
  initial forever #12.5 clk_sys = ~clk_sys;
  task tick(input integer n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Register write, one strobe cycle then one idle cycle.
  task wr(input [7:0] a, input [15:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    tick(1);
    regWr <= 1'b0;
    tick(1);
  endtask
  // Register read; the data stand only in the cycle after the strobe.
  task rd(input [7:0] a);
    regAddr <= a;
    regRd <= 1'b1;
    tick(1);
    regRd <= 1'b0;
    #1 v = regRdData_q;
    tick(1);
  endtask
  // End of initialisation releases the indication at once.
  task eoi;
    endOfInitInstruction <= 1'b1;
    tick(1);
    endOfInitInstruction <= 1'b0;
    #1 `CHK("indication", 1'b1, resetIndicationOutN)
    tick(1);
  endtask
  // Waits a bounded time for a core reset, then lets it finish.
  task waitCore;
    #1 i = 0;
    while (coreReset !== 1'b1 && i < 6) begin
      tick(1);
      #1 i = i + 1;
    end
    `CHK("coreReset", 1'b1, coreReset)
    `CHK("indication", 1'b0, resetIndicationOutN)
    tick(3);
  endtask
  // Every strap code through a pin reset; straps move after release.
  task t_straps;
    for (integer c = 0; c < 8; c = c + 1) begin
      brd.pulse(c[2:0]);
      rd(`RBCS_OFS_STAT);
      `CHK("code", c[2:0], v[2:0])
      `CHK("cause", 2'h1, v[9:8])
      `CHK("ext", c < 4, extBusActive)
      `CHK("rsvd", c > 4, cfgReserved)
      if (c < 4) begin
        `CHK("wide", c == 2 || c == 3, busWide16)
        `CHK("mux", c == 1 || c == 2, busMultiplexed)
      end
      `CHK("indication", 1'b0, resetIndicationOutN)
      eoi;
    end
    brd.pulse(3'h0);
    eoi;
  endtask
  // Software reset clears the port setup.
  task t_soft;
    wr(`RBCS_OFS_CTRL, 16'h0003);
    wr(`RBCS_OFS_CMD, 16'h0001);
    waitCore;
    rd(`RBCS_OFS_CTRL);
    `CHK("ctrl", 16'h0000, v)
    rd(`RBCS_OFS_STAT);
    `CHK("cause", 2'h2, v[9:8])
    `CHK("oe", 1'b0, segmentPortPinLoOe)
    eoi;
  endtask
  // Watchdog reset keeps the latched bus setup.
  task t_wdt;
    watchdogResetReq <= 1'b1;
    tick(1);
    watchdogResetReq <= 1'b0;
    waitCore;
    rd(`RBCS_OFS_STAT);
    `CHK("cause", 2'h3, v[9:8])
    `CHK("ext", 1'b1, extBusActive)
    eoi;
  endtask
  // Checks {HiOe, HiOut, LoOe, LoOut} once settled.
  task pins(input [3:0] e);
    tick(2);
    #1 `CHK("pins", e, pinView)
    tick(1);
  endtask
  // Segment pins carry A16 and A17 or port data per the segment enable, enables per direction.
  task t_seg;
    segAddr <= 2'h1;
    wr(`RBCS_OFS_CTRL, 16'h0013);
    pins(4'hb);
    segAddr <= 2'h2;
    pins(4'he);
    extHi <= 1'b0;
    wr(`RBCS_OFS_CTRL, 16'h000d);
    pins(4'h7);
    tick(4);
    rd(`RBCS_OFS_STAT);
    `CHK("pin levels", 2'h1, v[6:5])
  endtask
  // Unmapped and write-only places read as zero.
  task t_map;
    rd(8'h7c);
    `CHK("unmapped", 16'h0000, v)
    rd(`RBCS_OFS_CMD);
    `CHK("cmd read", 16'h0000, v)
  endtask
  // A reset pulse shorter than the minimum is ignored.
  task t_short;
    brd.blip;
    tick(8);
    #1 `CHK("short coreReset", 1'b0, coreReset)
    `CHK("short indication", 1'b1, resetIndicationOutN)
    tick(1);
  endtask
  // Verdict and end of run.
  task stop_test;
    if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence.
  initial begin
    tick(5);
    rst <= 1'b0;
    tick(1);
    t_straps;
    t_soft;
    t_wdt;
    t_seg;
    t_map;
    t_short;
    stop_test;
  end
  // Watchdog against a hang.
  initial begin
    tick(3000);
    n_errors = n_errors + 1;
    stop_test;
  end
endmodule // tb
bind rbcs_top rbcs_top_chk chk (.clk_sys, .rst, .resetRequestInN, .endOfInitInstruction,
  .watchdogResetReq, .regAddr, .regWrData, .regWr, .regRd, .regRdData_q, .resetIndicationOutN,
  .coreReset, .coreClk, .extBusActive, .cfgReserved, .segmentPortPinLoOe, .segmentPortPinHiOe);
